// [core/serial_command_port_consts.svh]
// Constants for the serial command port: bit counts, command codes, field positions, reset values
`ifndef SERIAL_COMMAND_PORT_CONSTS_SVH
`define SERIAL_COMMAND_PORT_CONSTS_SVH

`define SCP_BIT_ZERO 3'h0
`define SCP_BIT_LAST 3'h7
`define SCP_BIT_STEP 3'h1
`define SCP_BYTE_CLR 8'h00
`define SCP_STAT_PAD 4'h0

`define SCP_PUP_MASK 8'hFE
`define SCP_PUP_CODE 8'h00
`define SCP_WCM_BIT 0
`define SCP_ANALOG_SETUP_CMD_MASK 8'hFC
`define SCP_ANALOG_SETUP_CMD_CODE 8'h04
`define SCP_MIXED_VOLUME_CMD_CODE 8'h08
`define SCP_NIB_MASK 8'hF0
`define SCP_PHRASE_SELECT_CMD_CODE 8'h30
`define SCP_PLAY_CODE 8'h40
`define SCP_SILENCE_INSERT_CMD_CODE 8'h50
`define SCP_CHANNEL_VOLUME_CMD_CODE 8'h70
`define SCP_FAULT_CLEAR_CMD_CODE 8'hB0

`define SCP_CH_HI 3
`define SCP_CH_LO 2
`define SCP_CHANNEL_VOLUME_CMD_HI 4
`define SCP_CHANNEL_VOLUME_CMD_LO 0
`define SCP_CHANNEL_VOLUME_CMD_W 5
`define SCP_MIXED_VOLUME_CMD_HI 5
`define SCP_MIXED_VOLUME_CMD_LO 0
`define SCP_GAIN_HI 6
`define SCP_GAIN_LO 3

`define SCP_CHANNEL_VOLUME_CMD_RST 5'h00
`define SCP_MIXED_VOLUME_CMD_RST 6'h00
`define SCP_GAIN_RST 4'h0

`endif

// [core/serial_command_port_pkg.sv]
// Types shared by the serial command port
package serial_command_port_pkg;

    typedef logic [7:0] byte_t;

    typedef enum logic [1:0] {
        CMD_OPCODE = 2'b00,
        CMD_OPERAND = 2'b01
    } cmd_state_t;

endpackage

// [core/edge_link_if.sv]
// Carrier for a synchronised pin level and its edge pulses
`timescale 1ns/1ps
interface edge_link_if;
    logic level;
    logic rise;
    logic fall;
    modport source (output level, output rise, output fall);
    modport sink (input level, input rise, input fall);
endinterface

// [core/serial_edge_detect.sv]
// Two-flop synchroniser with edge detection for one pin
`timescale 1ns/1ps
module serial_edge_detect #(
    parameter logic idle_level = 1'b0
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic pin_in,
    edge_link_if.source link
);
    logic meta_r, meta_nxt;
    logic sync_r, sync_nxt;
    logic prev_r, prev_nxt;

    always_comb begin
        meta_nxt = pin_in;
        sync_nxt = meta_r;
        prev_nxt = sync_r;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            // Reset to the pin's idle level so no false edge follows reset
            meta_r <= idle_level;
            sync_r <= idle_level;
            prev_r <= idle_level;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
            prev_r <= prev_nxt;
        end
    end

    assign link.level = sync_r;
    assign link.rise = sync_r && !prev_r;
    assign link.fall = !sync_r && prev_r;
endmodule

// [core/serial_command_port.sv]
// Serial command and status port: byte framing, double-entry check, command decode
// Function
// R1 - Host lowers chip select, sends command bytes MSB first, one bit per clock.
// R2 - Command executes at the eighth active serial clock edge of the byte.
// R3 - While chip select low, status bits are driven out in step with clock.
// R4 - Edge select low: sample input on rising, change output on falling edges.
// R5 - Edge select high: sample input on falling, change output on rising edges.
// R6 - Commands accepted with chip select held low, framed by counting edges.
// R7 - Chip select high resets interface, dropping partial byte and bit count.
// R8 - Serial data output is released whenever chip select is high.
// R9 - Status read shifts out each playback channel's status in turn.
// R10 - Double-entry mode is set only by the power-up command.
// R11 - In double-entry mode host sends each byte twice in a row.
// R12 - In double-entry mode a command runs only if both copies match.
// R13 - A copy mismatch raises the error output and keeps it high.
// R14 - The error output clears only on the fault clear command.
// R15 - Channel, mixed and analog gain volume are set by three separate commands.
// R16 - Host sends only while busy output is high; six commands take two bytes.
// R17 - Power-up command has bits 7..1 zero; bit 0 selects double-entry mode.
// R18 - Bit counter restarts after each byte so framing continues with select low.
`timescale 1ns/1ps
`include "serial_command_port_consts.svh"
module serial_command_port (
    input wire logic clock,
    input wire logic rst,
    input wire logic chip_select_n,
    input wire logic serial_clk,
    input wire logic serial_din,
    input wire logic edge_select_pin,
    input wire logic [3:0] channel_status,
    input wire logic core_busy,
    output logic serial_dout,
    output logic serial_dout_oe,
    output logic error_out,
    output logic command_busy_n,
    output logic double_entry_mode,
    output logic cmd_valid,
    output serial_command_port_pkg::byte_t cmd_code,
    output serial_command_port_pkg::byte_t cmd_data,
    output logic [19:0] channel_volume,
    output logic [5:0] mixed_volume,
    output logic [3:0] analog_gain
);
    import serial_command_port_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    edge_link_if sck_link();
    edge_link_if cs_link();
    edge_link_if din_link();
    edge_link_if phase_link();

    serial_edge_detect u_sck (.clock(clock), .rst(rst), .pin_in(serial_clk), .link(sck_link.source));
    // Select idles high, so the output stays released through reset
    serial_edge_detect #(.idle_level(1'b1)) u_cs (.clock(clock), .rst(rst), .pin_in(chip_select_n), .link(cs_link.source));
    serial_edge_detect u_din (.clock(clock), .rst(rst), .pin_in(serial_din), .link(din_link.source));
    serial_edge_detect u_phase (.clock(clock), .rst(rst), .pin_in(edge_select_pin), .link(phase_link.source));

    logic cs_high;
    logic samp_edge;
    logic launch_edge;

    assign cs_high = cs_link.level;
    // Edges count only while selected; a permanently low select still frames bytes
    assign samp_edge = !cs_high && (phase_link.level ? sck_link.fall : sck_link.rise); // R4 R5 R6
    assign launch_edge = !cs_high && (phase_link.level ? sck_link.rise : sck_link.fall); // R4 R5

    ////////////////////////////////////////////////////////////////////////////////
    // Bit shifting
    logic [2:0] bit_cnt_r, bit_cnt_nxt;
    byte_t in_shift_r, in_shift_nxt;
    byte_t out_shift_r, out_shift_nxt;
    logic byte_done;
    byte_t byte_val;

    always_comb begin
        bit_cnt_nxt = bit_cnt_r;
        in_shift_nxt = in_shift_r;
        out_shift_nxt = out_shift_r;
        byte_done = 1'b0;
        byte_val = {in_shift_r[6:0], din_link.level};
        if (cs_high) begin
            bit_cnt_nxt = `SCP_BIT_ZERO; // R7
            in_shift_nxt = `SCP_BYTE_CLR; // R7
            out_shift_nxt = {channel_status, `SCP_STAT_PAD}; // R9
        end else begin
            if (samp_edge) begin
                in_shift_nxt = byte_val;
                if (bit_cnt_r == `SCP_BIT_LAST) begin
                    byte_done = 1'b1; // R2
                    bit_cnt_nxt = `SCP_BIT_ZERO; // R18
                end else begin
                    bit_cnt_nxt = bit_cnt_r + `SCP_BIT_STEP;
                end
            end
            if (launch_edge) begin
                // A fresh status snapshot starts every byte
                if (bit_cnt_r == `SCP_BIT_ZERO) begin
                    out_shift_nxt = {channel_status, `SCP_STAT_PAD}; // R9
                end else begin
                    out_shift_nxt = {out_shift_r[6:0], 1'b0}; // R3
                end
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            bit_cnt_r <= `SCP_BIT_ZERO;
            in_shift_r <= `SCP_BYTE_CLR;
            out_shift_r <= `SCP_BYTE_CLR;
        end else begin
            bit_cnt_r <= bit_cnt_nxt;
            in_shift_r <= in_shift_nxt;
            out_shift_r <= out_shift_nxt;
        end
    end

    assign serial_dout = out_shift_r[7]; // R3
    assign serial_dout_oe = !cs_high; // R8

    ////////////////////////////////////////////////////////////////////////////////
    // Double-entry check and command decode
    function automatic logic is_two_byte(input byte_t c);
        is_two_byte = ((c & `SCP_ANALOG_SETUP_CMD_MASK) == `SCP_ANALOG_SETUP_CMD_CODE) || (c == `SCP_MIXED_VOLUME_CMD_CODE) ||
                      ((c & `SCP_NIB_MASK) == `SCP_PHRASE_SELECT_CMD_CODE) || ((c & `SCP_NIB_MASK) == `SCP_PLAY_CODE) ||
                      ((c & `SCP_NIB_MASK) == `SCP_SILENCE_INSERT_CMD_CODE) || ((c & `SCP_NIB_MASK) == `SCP_CHANNEL_VOLUME_CMD_CODE);
    endfunction

    cmd_state_t state_r, state_nxt;
    byte_t first_r, first_nxt;
    logic de_have_r, de_have_nxt;
    byte_t de_copy_r, de_copy_nxt;
    logic mode_r, mode_nxt;
    logic err_r, err_nxt;
    logic cmd_valid_r, cmd_valid_nxt;
    byte_t cmd_code_r, cmd_code_nxt;
    byte_t cmd_data_r, cmd_data_nxt;
    logic [4:0] chan_vol_r [0:3];
    logic [4:0] chan_vol_nxt [0:3];
    logic [5:0] mix_vol_r, mix_vol_nxt;
    logic [3:0] gain_r, gain_nxt;
    logic busy_n_r, busy_n_nxt;
    logic exec;
    logic mismatch;
    logic pup_exec;
    logic clear_exec;

    always_comb begin
        state_nxt = state_r;
        first_nxt = first_r;
        de_have_nxt = de_have_r;
        de_copy_nxt = de_copy_r;
        mode_nxt = mode_r;
        err_nxt = err_r;
        cmd_valid_nxt = 1'b0;
        cmd_code_nxt = cmd_code_r;
        cmd_data_nxt = cmd_data_r;
        chan_vol_nxt = chan_vol_r;
        mix_vol_nxt = mix_vol_r;
        gain_nxt = gain_r;
        busy_n_nxt = !core_busy;
        exec = 1'b0;
        mismatch = 1'b0;
        pup_exec = 1'b0;
        clear_exec = 1'b0;
        if (cs_high) begin
            de_have_nxt = 1'b0; // R7
        end else if (byte_done) begin
            if (mode_r) begin
                if (!de_have_r) begin
                    de_have_nxt = 1'b1; // R11
                    de_copy_nxt = byte_val;
                end else begin
                    de_have_nxt = 1'b0;
                    if (byte_val == de_copy_r) begin
                        exec = 1'b1; // R12
                    end else begin
                        mismatch = 1'b1; // R12
                    end
                end
            end else begin
                exec = 1'b1; // R2
            end
        end
        if (mismatch) begin
            err_nxt = 1'b1; // R13
        end
        if (exec) begin
            case (state_r)
                CMD_OPCODE: begin
                    if (is_two_byte(byte_val)) begin
                        state_nxt = CMD_OPERAND; // R16
                        first_nxt = byte_val;
                    end else begin
                        cmd_valid_nxt = 1'b1;
                        cmd_code_nxt = byte_val;
                        cmd_data_nxt = `SCP_BYTE_CLR;
                        if ((byte_val & `SCP_PUP_MASK) == `SCP_PUP_CODE) begin
                            pup_exec = 1'b1;
                            mode_nxt = byte_val[`SCP_WCM_BIT]; // R10 R17
                        end
                        if (byte_val == `SCP_FAULT_CLEAR_CMD_CODE) begin
                            clear_exec = 1'b1;
                            err_nxt = 1'b0; // R14
                        end
                    end
                end
                CMD_OPERAND: begin
                    state_nxt = CMD_OPCODE;
                    cmd_valid_nxt = 1'b1;
                    cmd_code_nxt = first_r;
                    cmd_data_nxt = byte_val;
                    if ((first_r & `SCP_NIB_MASK) == `SCP_CHANNEL_VOLUME_CMD_CODE) begin
                        chan_vol_nxt[first_r[`SCP_CH_HI:`SCP_CH_LO]] = byte_val[`SCP_CHANNEL_VOLUME_CMD_HI:`SCP_CHANNEL_VOLUME_CMD_LO]; // R15
                    end
                    if (first_r == `SCP_MIXED_VOLUME_CMD_CODE) begin
                        mix_vol_nxt = byte_val[`SCP_MIXED_VOLUME_CMD_HI:`SCP_MIXED_VOLUME_CMD_LO]; // R15
                    end
                    if ((first_r & `SCP_ANALOG_SETUP_CMD_MASK) == `SCP_ANALOG_SETUP_CMD_CODE) begin
                        gain_nxt = byte_val[`SCP_GAIN_HI:`SCP_GAIN_LO]; // R15
                    end
                end
                default: begin
                    state_nxt = CMD_OPCODE;
                end
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_r <= CMD_OPCODE;
            first_r <= `SCP_BYTE_CLR;
            de_have_r <= 1'b0;
            de_copy_r <= `SCP_BYTE_CLR;
            mode_r <= 1'b0;
            err_r <= 1'b0;
            cmd_valid_r <= 1'b0;
            cmd_code_r <= `SCP_BYTE_CLR;
            cmd_data_r <= `SCP_BYTE_CLR;
            for (int i = 0; i < 4; i++) begin
                chan_vol_r[i] <= `SCP_CHANNEL_VOLUME_CMD_RST;
            end
            mix_vol_r <= `SCP_MIXED_VOLUME_CMD_RST;
            gain_r <= `SCP_GAIN_RST;
            busy_n_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            first_r <= first_nxt;
            de_have_r <= de_have_nxt;
            de_copy_r <= de_copy_nxt;
            mode_r <= mode_nxt;
            err_r <= err_nxt;
            cmd_valid_r <= cmd_valid_nxt;
            cmd_code_r <= cmd_code_nxt;
            cmd_data_r <= cmd_data_nxt;
            chan_vol_r <= chan_vol_nxt;
            mix_vol_r <= mix_vol_nxt;
            gain_r <= gain_nxt;
            busy_n_r <= busy_n_nxt;
        end
    end

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            channel_volume[i*`SCP_CHANNEL_VOLUME_CMD_W +: `SCP_CHANNEL_VOLUME_CMD_W] = chan_vol_r[i];
        end
    end

    assign error_out = err_r;
    assign command_busy_n = busy_n_r;
    assign double_entry_mode = mode_r;
    assign cmd_valid = cmd_valid_r;
    assign cmd_code = cmd_code_r;
    assign cmd_data = cmd_data_r;
    assign mixed_volume = mix_vol_r;
    assign analog_gain = gain_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence s_last_sample;
        samp_edge && (bit_cnt_r == `SCP_BIT_LAST);
    endsequence

    sequence s_byte_closed;
        (bit_cnt_r == `SCP_BIT_ZERO) ##0 (in_shift_r == $past(byte_val));
    endsequence

    property p_select_releases_dout;
        chip_select_n [*4] |-> !serial_dout_oe;
    endproperty
    a_select_releases_dout: assert property (p_select_releases_dout) else $error("dout driven while deselected"); // R8

    property p_eighth_edge;
        s_last_sample |=> s_byte_closed;
    endproperty
    a_eighth_edge: assert property (p_eighth_edge) else $error("byte not closed on eighth edge"); // R2 R18

    property p_select_resets;
        cs_high |=> (bit_cnt_r == `SCP_BIT_ZERO) && !de_have_r;
    endproperty
    a_select_resets: assert property (p_select_resets) else $error("interface not reset by select"); // R7

    property p_count_only_edges;
        !samp_edge && !cs_high |=> $stable(bit_cnt_r);
    endproperty
    a_count_only_edges: assert property (p_count_only_edges) else $error("bit count moved without edge"); // R2 R6

    property p_mismatch_flags;
        mismatch |=> error_out && !cmd_valid;
    endproperty
    a_mismatch_flags: assert property (p_mismatch_flags) else $error("mismatch not flagged"); // R12 R13

    property p_error_sticky;
        error_out && !clear_exec |=> error_out;
    endproperty
    a_error_sticky: assert property (p_error_sticky) else $error("error dropped without clear"); // R13 R14

    property p_mode_from_pup;
        $changed(double_entry_mode) |-> $past(pup_exec);
    endproperty
    a_mode_from_pup: assert property (p_mode_from_pup) else $error("mode changed without power-up"); // R10

    property p_dout_on_launch;
        !launch_edge && !cs_high |=> $stable(serial_dout);
    endproperty
    a_dout_on_launch: assert property (p_dout_on_launch) else $error("dout moved off launch edge"); // R3 R4 R5

    property p_status_first_bit;
        launch_edge && (bit_cnt_r == `SCP_BIT_ZERO) |=> serial_dout == $past(channel_status[3]);
    endproperty
    a_status_first_bit: assert property (p_status_first_bit) else $error("status not loaded"); // R9
endmodule

// [test/host_model.sv]
// Host controller model driving the serial command pins
`timescale 1ns/1ps
module host_model (
    input wire logic clock,
    input wire logic edge_sel,
    input wire logic busy_n,
    input wire logic so_line,
    output logic chip_select_n,
    output logic serial_clk,
    output logic serial_din
);
    initial begin
        chip_select_n = 1'b1;
        serial_clk = 1'b0;
        serial_din = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // Serial clock rests at the idle level of the chosen edge polarity
    task automatic park();
        serial_clk = edge_sel;
        wait_clk(6);
    endtask

    task automatic select(input logic csn);
        chip_select_n = csn;
        wait_clk(6);
    endtask

    // Active edge leaves idle, return to idle is the launch edge; read just before launch
    task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
        int t;
        rx = 8'h00;
        for (int i = 0; i < n; i++) begin
            t = 0;
            while (busy_n !== 1'b1 && t < 1000) begin
                wait_clk(1);
                t++;
            end
            serial_din = tx[7 - i];
            wait_clk(4);
            serial_clk = ~edge_sel;
            wait_clk(3);
            rx = {rx[6:0], so_line};
            wait_clk(1);
            serial_clk = edge_sel;
        end
        serial_din = ~serial_din;
    endtask
endmodule

// [test/tb_serial_command_port.sv]
// Testbench for the serial command port
`timescale 1ns/1ps
module tb_serial_command_port;
    import serial_command_port_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic edge_select_pin;
    logic [3:0] channel_status;
    logic core_busy;
    logic so_last = 1'b0;
    logic chip_select_n, serial_clk, serial_din, serial_dout, serial_dout_oe, so_line;
    logic error_out, command_busy_n, double_entry_mode, cmd_valid;
    byte_t cmd_code, cmd_data, last_code, last_data, rx;
    logic [19:0] channel_volume;
    logic [5:0] mixed_volume;
    logic [3:0] analog_gain;
    int error_cnt = 0;
    int n_compared = 0;
    int n_valid = 0;
    int cycles = 0;
    int base;

    always #12.5 clock = ~clock;

    // Released data out shows the inverse of its last driven value
    always @(posedge clock) if (serial_dout_oe === 1'b1) so_last <= serial_dout;
    assign so_line = (serial_dout_oe === 1'b1) ? serial_dout : ~so_last;

    serial_command_port u_serial_command_port (
        .clock(clock),
        .rst(rst),
        .chip_select_n(chip_select_n),
        .serial_clk(serial_clk),
        .serial_din(serial_din),
        .edge_select_pin(edge_select_pin),
        .channel_status(channel_status),
        .core_busy(core_busy),
        .serial_dout(serial_dout),
        .serial_dout_oe(serial_dout_oe),
        .error_out(error_out),
        .command_busy_n(command_busy_n),
        .double_entry_mode(double_entry_mode),
        .cmd_valid(cmd_valid),
        .cmd_code(cmd_code),
        .cmd_data(cmd_data),
        .channel_volume(channel_volume),
        .mixed_volume(mixed_volume),
        .analog_gain(analog_gain)
    );

    host_model u_host_model (
        .clock(clock),
        .edge_sel(edge_select_pin),
        .busy_n(command_busy_n),
        .so_line(so_line),
        .chip_select_n(chip_select_n),
        .serial_clk(serial_clk),
        .serial_din(serial_din)
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [19:0] got, input logic [19:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask

    task automatic cmd(input byte_t b);
        u_host_model.xfer(b, 8, rx);
    endtask

    task automatic settle();
        u_host_model.wait_clk(8);
    endtask

    // Accepted commands are logged so counts and codes can be compared
    always @(posedge clock) begin
        cycles++;
        if (cmd_valid === 1'b1) begin
            n_valid++;
            last_code = cmd_code;
            last_data = cmd_data;
        end
        if (cycles == 20000) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: timeout", $time);
            conclude();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        edge_select_pin = 1'b0;
        channel_status = 4'h0;
        core_busy = 1'b0;
        repeat (3) @(posedge clock);
        #1;
        rst = 1'b0;
        u_host_model.wait_clk(6);
        chk({error_out, command_busy_n, double_entry_mode, serial_dout_oe}, 4'b0100, "reset flags");
        chk(channel_volume, 20'h00000, "channel volume reset");
        chk({mixed_volume, analog_gain}, 10'h000, "volume reset");
        core_busy = 1'b1;
        u_host_model.wait_clk(3);
        chk(command_busy_n, 1'b0, "busy low");
        core_busy = 1'b0;
        u_host_model.wait_clk(3);
        chk(command_busy_n, 1'b1, "busy high");
        $display("test reset done");

        u_host_model.select(1'b0);
        chk(serial_dout_oe, 1'b1, "drive when selected");
        base = n_valid;
        u_host_model.xfer(8'h20, 7, rx);
        settle();
        chk(20'(n_valid - base), 20'h0, "no command at seventh edge");
        u_host_model.xfer(8'h00, 1, rx);
        settle();
        chk(20'(n_valid - base), 20'h1, "command at eighth edge");
        chk(last_code, 8'h20, "code");
        u_host_model.xfer(8'hFF, 5, rx);
        u_host_model.select(1'b1);
        chk(serial_dout_oe, 1'b0, "released when deselected");
        u_host_model.select(1'b0);
        cmd(8'h20);
        settle();
        chk(last_code, 8'h20, "partial byte dropped");
        chk(20'(n_valid - base), 20'h2, "count after deselect");
        $display("test framing done");

        for (int ch = 0; ch < 4; ch++) begin
            cmd(8'h70 + 8'(ch * 4));
            cmd(8'h11 + 8'(ch));
            settle();
            chk(channel_volume[5 * ch +: 5], 5'h11 + 5'(ch), "channel volume");
            chk(last_data, 8'h11 + 8'(ch), "second byte");
        end
        u_host_model.select(1'b1);
        $display("test channel volume done");

        edge_select_pin = 1'b1;
        u_host_model.park();
        u_host_model.select(1'b0);
        cmd(8'h08);
        cmd(8'h2A);
        cmd(8'h04);
        cmd(8'h50);
        settle();
        chk(mixed_volume, 6'h2A, "mixed volume");
        chk(analog_gain, 4'hA, "analog gain");
        for (int k = 3; k < 6; k++) begin
            cmd(8'(k * 16));
            cmd(8'(k * 16 + 5));
            settle();
            chk({last_code, last_data}, {8'(k * 16), 8'(k * 16 + 5)}, "two-byte command");
        end
        u_host_model.select(1'b1);
        $display("test falling edge done");

        for (int e = 0; e < 2; e++) begin
            edge_select_pin = e[0];
            channel_status = e[0] ? 4'hA : 4'h6;
            u_host_model.park();
            u_host_model.select(1'b0);
            u_host_model.xfer(8'hB0, 8, rx);
            chk(rx, {channel_status, 4'h0}, "status byte");
            u_host_model.select(1'b1);
        end
        $display("test status done");

        u_host_model.select(1'b0);
        cmd(8'h21);
        settle();
        chk(double_entry_mode, 1'b0, "mode from other command");
        cmd(8'h01);
        settle();
        chk(double_entry_mode, 1'b1, "mode set");
        base = n_valid;
        cmd(8'h08);
        cmd(8'h08);
        cmd(8'h15);
        cmd(8'h15);
        settle();
        chk(mixed_volume, 6'h15, "matched copies");
        chk(20'(n_valid - base), 20'h1, "one command per pair");
        u_host_model.select(1'b1);
        u_host_model.select(1'b0);
        cmd(8'h08);
        cmd(8'h09);
        settle();
        chk(error_out, 1'b1, "mismatch flagged");
        chk(20'(n_valid - base), 20'h1, "mismatch not run");
        u_host_model.select(1'b1);
        u_host_model.select(1'b0);
        cmd(8'h20);
        cmd(8'h20);
        settle();
        chk(error_out, 1'b1, "flag held");
        cmd(8'hB0);
        cmd(8'hB0);
        settle();
        chk(error_out, 1'b0, "flag cleared");
        cmd(8'h00);
        cmd(8'h00);
        settle();
        chk(double_entry_mode, 1'b0, "mode off");
        u_host_model.select(1'b1);
        $display("test double entry done");
        conclude();
    end
endmodule
